// ==== hw/sync_edge.sv ====
// two-flop synchroniser with rise and fall pulse detection.
// assumes the input is asynchronous to clk_i; pulses last one cycle.
module sync_edge (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // asynchronous level in
    input  wire logic async_i,
    // synchronised level and edge pulses
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic meta_r;  // first stage, read only by the second
    logic sync_r;  // second stage, safe level
    logic prev_r;  // delayed copy for edge detection

    // synchroniser chain and history flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // one pulse per edge
    assign level_o = sync_r;
    assign rise_o  = sync_r & ~prev_r;
    assign fall_o  = ~sync_r & prev_r;

endmodule

// ==== hw/timer_mode_capture_control.sv ====
// one channel of a 16-bit up-counting timer with mode control and capture.
// assumes a classic wishbone master on clk_i and asynchronous timer pins.
//
// The Wishbone register port and the address map were left to the implementer.
module timer_mode_capture_control #(
    parameter int CHANNEL = 0  // channel number 0..9
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // timer pins and partner match outputs of channels 7, 8, 9
    input  wire logic        timer_input_a_i,
    input  wire logic        timer_input_b_i,
    input  wire logic [2:0]  partner_match_output_i,
    // own match output and counter state
    output logic             match_o,
    output logic [15:0]      counter_o
);

    // partner channel index by channel number
    localparam int PARTNER_IDX = (CHANNEL <= 1) ? 0 :
                                 (CHANNEL <= 4) ? 1 : 2;
    localparam bit HAS_PINS = (CHANNEL <= timer_mode_pkg::LAST_PIN_CHANNEL);

    // bus side state
    logic                        ack_r;       // one-cycle answer
    logic [31:0]                 rdata_r;     // registered read data
    logic                        enable_r;    // module enable bit
    logic                        run_r;       // run control bit
    timer_mode_pkg::mode_fields_t mode_r;     // mode setup fields
    logic [15:0]                 cmp_one_r;   // compare register one
    logic [15:0]                 cap_zero_r;  // capture register zero
    logic [15:0]                 cap_one_r;   // capture register one
    // counting state
    logic [15:0]                 counter_r;   // up-counter
    logic [15:0]                 counter_nxt; // next counter value
    logic [4:0]                  pre_r;       // prescaler
    logic                        match_r;     // registered match pulse
    // decoded helpers
    logic                        access;      // new bus request this cycle
    logic                        wr;          // write accepted now
    logic                        gated;       // register reachable
    logic                        sw_capture;  // software capture strobe
    logic                        tick;        // count clock event
    logic                        at_compare;  // counter equals compare one
    logic                        load_zero;   // hardware load of capture 0
    logic                        load_one;    // hardware load of capture 1
    // synchronised edges: index 0 input a, 1 input b, 2 partner match
    logic [2:0]                  raw_in;
    logic [2:0]                  rise;
    logic [2:0]                  fall;

    // edge source vector
    assign raw_in = {partner_match_output_i[PARTNER_IDX],
                     timer_input_b_i, timer_input_a_i};

    // one synchroniser per external source
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            sync_edge u_sync (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .async_i (raw_in[gi]),
                .level_o (),
                .rise_o  (rise[gi]),
                .fall_o  (fall[gi])
            );
        end
    endgenerate

    // bus request decode; each request answered one cycle later
    assign access = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr     = access & wb_we_i;
    // other registers are dead while the module is disabled
    assign gated  = enable_r;
    // writing zero to the software capture bit takes a snapshot
    assign sw_capture = wr & gated & (wb_adr_i == timer_mode_pkg::OFS_MODE)
                        & wb_sel_i[0]
                        & ~wb_dat_i[timer_mode_pkg::SW_CAP_BIT];

    // ack generation: high for exactly one cycle per request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    // module enable register, always reachable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_r <= 1'b0;
        end else if (wr && wb_adr_i == timer_mode_pkg::OFS_ENABLE
                     && wb_sel_i[0]) begin
            enable_r <= wb_dat_i[timer_mode_pkg::ENABLE_BIT];
        end
    end

    // run control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_r <= 1'b0;
        end else if (wr && gated && wb_adr_i == timer_mode_pkg::OFS_RUN
                     && wb_sel_i[0]) begin
            run_r <= wb_dat_i[timer_mode_pkg::RUN_BIT];
        end
    end

    // mode setup fields; bit 5 is a strobe and is not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= timer_mode_pkg::MODE_RST;
        end else if (wr && gated && wb_adr_i == timer_mode_pkg::OFS_MODE
                     && wb_sel_i[0]) begin
            mode_r <= timer_mode_pkg::mode_fields_t'({wb_dat_i[6],
                                                      wb_dat_i[4:0]});
        end
    end

    // compare register one, byte lanes 0 and 1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_one_r <= timer_mode_pkg::CMP_ONE_RST;
        end else if (wr && gated
                     && wb_adr_i == timer_mode_pkg::OFS_CMP_ONE) begin
            if (wb_sel_i[0]) begin
                cmp_one_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                cmp_one_r[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // read mux, registered so data stands with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (access) begin
            rdata_r <= 32'h0000_0000;
            if (wb_adr_i == timer_mode_pkg::OFS_ENABLE) begin
                rdata_r[timer_mode_pkg::ENABLE_BIT] <= enable_r;
            end else if (gated) begin
                case (wb_adr_i)
                    timer_mode_pkg::OFS_RUN: begin
                        rdata_r[timer_mode_pkg::RUN_BIT] <= run_r;
                    end
                    timer_mode_pkg::OFS_MODE: begin
                        rdata_r[4:0] <= mode_r[4:0];
                        rdata_r[timer_mode_pkg::SPARE_BIT] <= mode_r.spare;
                        rdata_r[timer_mode_pkg::SW_CAP_BIT] <= 1'b1;
                    end
                    timer_mode_pkg::OFS_COUNTER: begin
                        rdata_r[15:0] <= counter_r;
                    end
                    timer_mode_pkg::OFS_CMP_ONE: begin
                        rdata_r[15:0] <= cmp_one_r;
                    end
                    timer_mode_pkg::OFS_CAP_ZER: begin
                        rdata_r[15:0] <= cap_zero_r;
                    end
                    timer_mode_pkg::OFS_CAP_ONE: begin
                        rdata_r[15:0] <= cap_one_r;
                    end
                    default: begin
                        // unmapped offsets read as zero
                        rdata_r <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // prescaler runs only while the channel runs
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_r) begin
            pre_r <= 5'h00;
        end else if (gated) begin
            pre_r <= pre_r + 5'h01;
        end
    end

    // count clock selection
    always_comb begin
        case (mode_r.count_clock_select)
            timer_mode_pkg::CLK_INPUT_A: begin
                // pin source absent on channels without pins
                tick = HAS_PINS & rise[0];
            end
            timer_mode_pkg::CLK_TAP_ONE: begin
                tick = (pre_r & timer_mode_pkg::TAP_ONE_MASK)
                       == timer_mode_pkg::TAP_ONE_MASK;
            end
            timer_mode_pkg::CLK_TAP_FOUR: begin
                tick = (pre_r & timer_mode_pkg::TAP_FOUR_MASK)
                       == timer_mode_pkg::TAP_FOUR_MASK;
            end
            timer_mode_pkg::CLK_TAP_SIXTEEN: begin
                tick = (pre_r & timer_mode_pkg::TAP_SIXTEEN_MASK)
                       == timer_mode_pkg::TAP_SIXTEEN_MASK;
            end
            default: begin
                tick = 1'b0;
            end
        endcase
    end

    // next counter value: clear on match only when enabled to
    assign at_compare = (counter_r == cmp_one_r);
    always_comb begin
        counter_nxt = counter_r;
        if (tick) begin
            if (mode_r.counter_clear_control && at_compare) begin
                counter_nxt = timer_mode_pkg::COUNTER_RST;
            end else begin
                counter_nxt = counter_r + 16'h0001;
            end
        end
    end

    // up-counter: stop and clear when not running, frozen when disabled
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_r) begin
            counter_r <= timer_mode_pkg::COUNTER_RST;
        end else if (gated) begin
            counter_r <= counter_nxt;
        end
    end

    // match pulse when a count event finds the compare value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_r <= 1'b0;
        end else begin
            match_r <= gated & run_r & tick & at_compare;
        end
    end

    // hardware capture event decode
    always_comb begin
        load_zero = 1'b0;
        load_one  = 1'b0;
        case (mode_r.capture_timing_select)
            timer_mode_pkg::CAP_OFF: begin
                load_zero = 1'b0;
                load_one  = 1'b0;
            end
            timer_mode_pkg::CAP_A_RISE_B_RISE: begin
                load_zero = HAS_PINS & rise[0];
                load_one  = HAS_PINS & rise[1];
            end
            timer_mode_pkg::CAP_A_RISE_A_FALL: begin
                load_zero = HAS_PINS & rise[0];
                load_one  = HAS_PINS & fall[0];
            end
            timer_mode_pkg::CAP_MATCH_EDGES: begin
                load_zero = rise[2];
                load_one  = fall[2];
            end
            default: begin
                load_zero = 1'b0;
                load_one  = 1'b0;
            end
        endcase
    end

    // capture register zero: hardware edge or software strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_zero_r <= timer_mode_pkg::CAP_RST;
        end else if ((gated && load_zero) || sw_capture) begin
            cap_zero_r <= counter_r;
        end
    end

    // capture register one: hardware edge only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_one_r <= timer_mode_pkg::CAP_RST;
        end else if (gated && load_one) begin
            cap_one_r <= counter_r;
        end
    end

    // outputs
    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = rdata_r;
    assign match_o   = match_r;
    assign counter_o = counter_r;

endmodule

// ==== shared/timer_mode_pkg.sv ====
// timer channel package: register offsets, field layout, reset values,
// mode encodings and the carrier struct for the mode setup fields.
// assumes a 32-bit classic wishbone register bus on one clock.
package timer_mode_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_ENABLE  = 8'h00; // module enable
    localparam logic [7:0] OFS_RUN     = 8'h04; // run control
    localparam logic [7:0] OFS_MODE    = 8'h0C; // timer_mode_setup
    localparam logic [7:0] OFS_COUNTER = 8'h10; // up-counter, read only
    localparam logic [7:0] OFS_CMP_ONE = 8'h14; // compare_register_one
    localparam logic [7:0] OFS_CAP_ZER = 8'h18; // capture_register_zero
    localparam logic [7:0] OFS_CAP_ONE = 8'h1C; // capture_register_one

    // field positions
    localparam int ENABLE_BIT  = 7;  // channel_module_enable
    localparam int RUN_BIT     = 0;  // channel_run_control
    localparam int SW_CAP_BIT  = 5;  // software capture, reads one
    localparam int SPARE_BIT   = 6;  // plain r/w, write zero

    // reset values
    localparam logic [15:0] COUNTER_RST = 16'h0000;
    localparam logic [15:0] CMP_ONE_RST = 16'h0000;
    localparam logic [15:0] CAP_RST     = 16'h0000;

    // prescaler tap masks: a tap fires when the masked bits are all ones
    localparam logic [4:0] TAP_ONE_MASK     = 5'h01;
    localparam logic [4:0] TAP_FOUR_MASK    = 5'h07;
    localparam logic [4:0] TAP_SIXTEEN_MASK = 5'h1F;

    // highest channel that owns timer input pins
    localparam int LAST_PIN_CHANNEL = 6;

    // count clock sources
    typedef enum logic [1:0] {
        CLK_INPUT_A = 2'h0,
        CLK_TAP_ONE = 2'h1,
        CLK_TAP_FOUR = 2'h2,
        CLK_TAP_SIXTEEN = 2'h3
    } count_clock_t;

    // capture timing choices
    typedef enum logic [1:0] {
        CAP_OFF = 2'h0,
        CAP_A_RISE_B_RISE = 2'h1,
        CAP_A_RISE_A_FALL = 2'h2,
        CAP_MATCH_EDGES = 2'h3
    } capture_timing_t;

    // stored mode setup fields, bits 6..0 less the software capture bit
    typedef struct packed {
        logic            spare;
        capture_timing_t capture_timing_select;
        logic            counter_clear_control;
        count_clock_t    count_clock_select;
    } mode_fields_t;

    localparam mode_fields_t MODE_RST = '{
        spare: 1'b0,
        capture_timing_select: CAP_OFF,
        counter_clear_control: 1'b0,
        count_clock_select: CLK_INPUT_A
    };

endpackage

// ==== testbench/tb.sv ====
// bench for one timer channel and a pinless one: registers, counting, clear, captures, taps.
// assumes the package and the bound monitor are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // clock, reset and bus
    logic        clk_i;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [4:0]  pins     = 5'h00; // a, b, matches of channels 7, 8, 9
    logic        match_o;
    logic [15:0] counter_o;
    logic [15:0] cnt8;             // counter of the pinless channel
    logic [31:0] exp_q[$];         // expected read data
    logic        chk_q[$];         // whether the answer is checked
    int          miscompares = 0;
    int          checked     = 0;
    int          n;                // counter value expected
    int          m;
    int          c;                // compare value
    logic [15:0] c0;

    timer_mode_capture_control #(.CHANNEL(3)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .timer_input_a_i(pins[0]),
        .timer_input_b_i(pins[1]), .partner_match_output_i(pins[4:2]),
        .match_o(match_o), .counter_o(counter_o));

    // pinless channel on the same bus: input a must never clock it
    timer_mode_capture_control #(.CHANNEL(8)) uut_pinless (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(),
        .wb_ack_o(), .timer_input_a_i(pins[0]),
        .timer_input_b_i(pins[1]), .partner_match_output_i(pins[4:2]),
        .match_o(), .counter_o(cnt8));

    // verdict and end of run
    task automatic report_and_stop;
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; read data is noted for the watcher
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
        int t = 0;
        exp_q.push_back(d);
        chk_q.push_back(!we);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= we ? d : 32'h0;
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 20);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (t >= 20) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    // k pulses on one pin, long enough for the synchroniser
    task automatic pulse(input int p, input int k);
        repeat (k) begin
            @(posedge clk_i);
            pins[p] <= 1'b1;
            repeat (5) @(posedge clk_i);
            pins[p] <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
    endtask

    // take the oldest note at each answer and compare
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1) begin
            if (chk_q.pop_front()) begin
                cmp(wb_dat_o, exp_q.pop_front());
            end else begin
                void'(exp_q.pop_front());
            end
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial begin
        void'($urandom(23127));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // disabled and unmapped places read zero
        bus(1'b0, 8'h0C, 32'h0);
        bus(1'b1, 8'h08, 32'hFF);
        bus(1'b0, 8'h08, 32'h0);
        bus(1'b1, 8'h00, 32'h80);
        bus(1'b0, 8'h00, 32'h80);
        bus(1'b0, 8'h0C, 32'h20);
        bus(1'b0, 8'h10, 32'h0);
        bus(1'b0, 8'h18, 32'h0);
        bus(1'b0, 8'h1C, 32'h0);
        // clear on match while counting input a edges
        c = $urandom_range(5, 2);
        n = $urandom_range(12, 6); // always past the compare value
        bus(1'b1, 8'h14, c);
        bus(1'b0, 8'h14, c);
        bus(1'b1, 8'h0C, 32'h24);
        bus(1'b1, 8'h04, 32'h1);
        pulse(0, n);
        bus(1'b0, 8'h10, n % (c + 1));
        // stop clears, then free counting past the compare value
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        bus(1'b1, 8'h0C, 32'h20);
        bus(1'b1, 8'h04, 32'h1);
        pulse(0, n);
        bus(1'b0, 8'h10, n);
        cmp(32'(cnt8), 32'h0);
        // capture off: no edge loads anything
        for (int p = 0; p < 5; p++) begin
            pulse(p, 1);
        end
        n++;
        bus(1'b0, 8'h18, 32'h0);
        bus(1'b0, 8'h1C, 32'h0);
        // software capture on a written zero only
        bus(1'b1, 8'h0C, 32'h00);
        bus(1'b0, 8'h18, n);
        bus(1'b0, 8'h0C, 32'h20);
        pulse(0, 1);
        bus(1'b1, 8'h0C, 32'h20);
        bus(1'b0, 8'h18, n);
        n++;
        // each capture timing choice in turn
        bus(1'b1, 8'h0C, 32'h28);
        pulse(1, 1);
        bus(1'b0, 8'h1C, n);
        bus(1'b1, 8'h0C, 32'h30);
        pulse(0, 1);
        n++;
        bus(1'b0, 8'h1C, n);
        bus(1'b1, 8'h0C, 32'h38);
        pulse(3, 1);
        bus(1'b0, 8'h18, n);
        bus(1'b0, 8'h1C, n);
        m = n;
        pulse(0, 2);
        pulse(2, 1);
        pulse(4, 1);
        bus(1'b0, 8'h18, m);
        bus(1'b0, 8'h1C, m);
        // taps: exact event count over a 64-cycle window
        for (int s = 1; s < 4; s++) begin
            bus(1'b1, 8'h0C, 32'h20 | s);
            @(posedge clk_i);
            c0 = counter_o;
            repeat (64) @(posedge clk_i);
            cmp(32'(counter_o - c0), 32'h20 >> (2 * (s - 1)));
        end
        report_and_stop();
    end
endmodule

// ==== testbench/timer_mode_monitor.sv ====
// checker for one timer channel: bus answers, counter steps, stop,
// clear on match and the mode read-back.
// assumes it is bound to timer_mode_capture_control on one clock.
module timer_mode_monitor (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // bus side
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // counter side
    input wire logic        match_o,
    input wire logic [15:0] counter_o
);
    logic take;  // request taken at this edge
    logic wr;    // write taken with the low byte enabled
    logic en_r;  // shadow of the module enable
    logic clr_r; // shadow of the clear control
    logic run_r; // shadow of the run control
    logic rdm_r; // pending answer belongs to a mode read

    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr   = take && wb_we_i && wb_sel_i[0];

    // shadow controls; clear and run writes are ignored while disabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r  <= 1'b0;
            clr_r <= 1'b0;
            run_r <= 1'b0;
        end else if (wr && wb_adr_i == timer_mode_pkg::OFS_ENABLE) begin
            en_r <= wb_dat_i[timer_mode_pkg::ENABLE_BIT];
        end else if (wr && en_r && wb_adr_i == timer_mode_pkg::OFS_MODE) begin
            clr_r <= wb_dat_i[2];
        end else if (wr && en_r && wb_adr_i == timer_mode_pkg::OFS_RUN) begin
            run_r <= wb_dat_i[timer_mode_pkg::RUN_BIT];
        end
    end

    // note whether the next answer carries the mode register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdm_r <= 1'b0;
        end else if (take) begin
            rdm_r <= !wb_we_i && wb_adr_i == timer_mode_pkg::OFS_MODE;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a request, then a one-cycle answer
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence answer_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_answer_a: assert property (take_s |=> answer_s)
        else $error("bus answer is not one pulse after the request");
    idle_quiet_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("bus answer without a request");
    count_step_a: assert property (
        counter_o != $past(counter_o) |->
        counter_o == $past(counter_o) + 16'h1 || counter_o == 16'h0)
        else $error("counter moved by other than one step");
    stop_clear_a: assert property (
        !run_r ##1 !run_r |-> counter_o == 16'h0)
        else $error("stopped counter is not zero");
    clear_match_a: assert property (
        match_o && clr_r |-> counter_o == 16'h0)
        else $error("counter not cleared on compare match");
    free_run_a: assert property (
        match_o && !clr_r |-> counter_o == $past(counter_o) + 16'h1)
        else $error("counter cleared on match with clearing off");
    match_pulse_a: assert property (match_o |=> !match_o)
        else $error("match lasts more than one cycle");
    sw_readback_a: assert property (wb_ack_o && rdm_r |->
        wb_dat_o[timer_mode_pkg::SW_CAP_BIT] == en_r &&
        wb_dat_o[31:7] == 25'h0)
        else $error("mode read-back wrong in the capture bit");
endmodule

bind timer_mode_capture_control timer_mode_monitor mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .match_o(match_o), .counter_o(counter_o)
);
